// file: hdl/aicd_chan_decode.sv
// Combinational decode and legality check of one channel's configuration
`timescale 1ns/100ps
module aicd_chan_decode
  import aicd_pkg::*;
(
  // Channel words in, decode out
  aicd_dec_if.dec d
);
  logic [3:0] filt_code;
  logic [2:0] fmt_code;
  logic filt_bad;
  logic fmt_bad;
  logic type_bad;

  always_comb begin
    filt_code = d.filt_word[AICD_FILT_LSB +: 4];
    fmt_code = d.cfg_word[AICD_FMT_LSB +: 3];
    d.type_code = d.cfg_word[AICD_TYPE_LSB +: 6];
    // Spare codes and any set bit above the filter field are illegal
    filt_bad = (filt_code > AICD_FILT_MAX) || (d.filt_word[31:4] != 28'h0000000); // see R3
    fmt_bad = fmt_code > AICD_FMT_MAX; // see R6
    type_bad = d.type_code > AICD_TYPE_MAX; // see R13
    d.notch = filt_bad ? AICD_N60 : aicd_notch_t'(filt_code); // see R2
    d.fmt = fmt_bad ? AICD_RAW : aicd_fmt_t'(fmt_code); // see R5
    d.iclass = aicd_type_class(d.type_code); // see R9
    d.cfg_err = filt_bad || fmt_bad || type_bad;
  end
endmodule : aicd_chan_decode

// file: hdl/aicd_dec_if.sv
// Interface carrying one channel's configuration words and their decode
`timescale 1ns/100ps
interface aicd_dec_if;
  import aicd_pkg::*;
  logic [31:0] filt_word;
  logic [31:0] cfg_word;
  aicd_notch_t notch;
  aicd_fmt_t fmt;
  logic [5:0] type_code;
  aicd_class_t iclass;
  logic cfg_err;
  modport host (output filt_word, output cfg_word, input notch, input fmt, input type_code,
    input iclass, input cfg_err);
  modport dec (input filt_word, input cfg_word, output notch, output fmt, output type_code,
    output iclass, output cfg_err);
endinterface : aicd_dec_if

// file: hdl/aicd_irq.sv
// Sticky configuration error flags, enable mask and interrupt output
`timescale 1ns/100ps
module aicd_irq #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Events and software access
  input wire logic [N-1:0] ev,
  input wire logic clr_we,
  input wire logic en_we,
  input wire logic [N-1:0] wdata,
  // State
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] enable;
  } aicd_irq_t;
  aicd_irq_t s;
  aicd_irq_t next_s;

  always_comb begin
    next_s = s;
    // Set wins over a clear arriving in the same cycle
    if (clr_we) next_s.status = s.status & ~wdata;
    next_s.status = next_s.status | ev;
    if (en_we) next_s.enable = wdata;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) s <= '0;
    else s <= next_s;
  end

  assign status = s.status;
  assign enable = s.enable;
  assign irq = |(s.status & s.enable);

  chk_set_wins: assert property (@(posedge clk) disable iff (!rstn) ev[0] |=> status[0]) // see R3
    else $error("event lost against clear");
endmodule : aicd_irq

// file: hdl/aicd_pkg.sv
// Constants and types shared by the analog input configuration decoder
package aicd_pkg;
  // Register byte offsets
  localparam logic [7:0] AICD_CH_STRIDE = 8'h10;
  localparam logic [3:0] AICD_OFS_FILT = 4'h0;
  localparam logic [3:0] AICD_OFS_INCFG = 4'h4;
  localparam logic [3:0] AICD_OFS_CHSTAT = 4'h8;
  localparam logic [7:0] AICD_OFS_COND = 8'h40;
  localparam logic [7:0] AICD_OFS_IEN = 8'h44;
  localparam logic [7:0] AICD_OFS_ICLR = 8'h48;
  // Configuration word fields
  localparam int AICD_FILT_LSB = 0;
  localparam int AICD_TYPE_LSB = 0;
  localparam int AICD_FMT_LSB = 8;
  localparam logic [31:0] AICD_INCFG_MASK = 32'h0000073F;
  // Channel status fields
  localparam int AICD_ST_FILT_LSB = 0;
  localparam int AICD_ST_FMT_LSB = 8;
  localparam int AICD_ST_TYPE_LSB = 16;
  localparam int AICD_ST_CLASS_LSB = 24;
  localparam int AICD_ST_ERR_BIT = 31;
  // Reset values
  localparam logic [31:0] AICD_FILT_RST = 32'h00000000;
  localparam logic [31:0] AICD_INCFG_RST = 32'h00000000;
  // Highest legal codes and type code bands
  localparam logic [3:0] AICD_FILT_MAX = 4'h5;
  localparam logic [2:0] AICD_FMT_MAX = 3'h4;
  localparam logic [5:0] AICD_TYPE_MV_LO = 6'h06;
  localparam logic [5:0] AICD_TYPE_TC_LO = 6'h08;
  localparam logic [5:0] AICD_TYPE_RTD_LO = 6'h11;
  localparam logic [5:0] AICD_TYPE_RES_LO = 6'h1D;
  localparam logic [5:0] AICD_TYPE_MAX = 6'h20;
  // Bus responses
  localparam logic [1:0] AICD_RESP_OKAY = 2'h0;
  localparam logic [1:0] AICD_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    AICD_N60 = 4'b0000, AICD_N50 = 4'b0001, AICD_N10 = 4'b0010,
    AICD_N250 = 4'b0011, AICD_N500 = 4'b0100, AICD_N1K = 4'b0101
  } aicd_notch_t;

  typedef enum logic [2:0] {
    AICD_RAW = 3'b000, AICD_ENG = 3'b001, AICD_ENG10 = 3'b010,
    AICD_PID = 3'b011, AICD_PCT = 3'b100
  } aicd_fmt_t;

  typedef enum logic [2:0] {
    AICD_VOLT = 3'b000, AICD_CURR = 3'b001, AICD_MVOLT = 3'b010,
    AICD_TCPL = 3'b011, AICD_RTD = 3'b100, AICD_RES = 3'b101, AICD_NONE = 3'b111
  } aicd_class_t;

  // Sensor class of a type and range code
  function automatic aicd_class_t aicd_type_class(input logic [5:0] code);
    if (code > AICD_TYPE_MAX) return AICD_NONE;
    if (code >= AICD_TYPE_RES_LO) return AICD_RES;
    if (code >= AICD_TYPE_RTD_LO) return AICD_RTD;
    if (code >= AICD_TYPE_TC_LO) return AICD_TCPL;
    if (code >= AICD_TYPE_MV_LO) return AICD_MVOLT;
    if (code == 6'h03 || code == 6'h05) return AICD_CURR;
    return AICD_VOLT;
  endfunction : aicd_type_class
endpackage : aicd_pkg

// file: hdl/aicd_top.sv
// Analog input configuration decoder with AXI4-Lite register access
//
// Overview of operation
// R1: Filter code sits in bits 3..0
// R2: Filter codes 0-5 select notch frequency
// R3: Filter codes 6-15 raise configuration error
// R4: Data format sits in bits 10..8
// R5: Format codes 0-4 select reporting form
// R6: Format codes 5-7 raise configuration error
// R7: Unused configuration bits are held zero
// R8: Type and range in bits 5..0
// R9: Type codes 0-7 are voltage/current ranges
// R10: Codes 8-16 are thermocouple types
// R11: Codes 17-28 are resistance thermometers
// R12: Codes 29-32 are plain resistance ranges
// R13: Codes 33-63 raise configuration error
`timescale 1ns/100ps
module aicd_top
  import aicd_pkg::*;
#(
  parameter int NCH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Applied settings toward the converter
  output logic [NCH*4-1:0] ch_notch,
  output logic [NCH*3-1:0] ch_format,
  output logic [NCH*6-1:0] ch_type,
  output logic [NCH*3-1:0] ch_class,
  output logic [NCH-1:0] ch_cfg_err,
  // Module condition and interrupt
  output logic [NCH-1:0] mod_cond,
  output logic irq
);
  localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;

  typedef struct packed {
    logic [NCH-1:0][31:0] filt;
    logic [NCH-1:0][31:0] cfg;
    logic [NCH-1:0][3:0] ap_notch;
    logic [NCH-1:0][2:0] ap_fmt;
    logic [NCH-1:0][5:0] ap_type;
    logic [NCH-1:0][2:0] ap_class;
    logic [NCH-1:0] ch_err;
    logic [NCH-1:0] upd;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aicd_state_t;

  aicd_state_t s;
  aicd_state_t next_s;

  logic [NCH-1:0] dec_err;
  logic [NCH-1:0][3:0] dec_notch;
  logic [NCH-1:0][2:0] dec_fmt;
  logic [NCH-1:0][5:0] dec_type;
  logic [NCH-1:0][2:0] dec_class;
  logic [NCH-1:0] ev;
  logic [NCH-1:0] irq_en;
  logic wr_fire;
  logic ien_we;
  logic iclr_we;

  function automatic logic is_chan(input logic [7:0] a);
    return (32'(a[7:4]) < NCH) && (a[3:2] != 2'b11) && (a[1:0] == 2'b00);
  endfunction : is_chan

  function automatic logic [CHW-1:0] chan_of(input logic [7:0] a);
    return CHW'(a[7:4]);
  endfunction : chan_of

  function automatic logic addr_ok(input logic [7:0] a);
    return is_chan(a) || (a == AICD_OFS_COND) || (a == AICD_OFS_IEN) || (a == AICD_OFS_ICLR);
  endfunction : addr_ok

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // Per-channel decoders
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    aicd_dec_if dif ();
    aicd_chan_decode u_dec (
      .d(dif.dec)
    );
    assign dif.filt_word = s.filt[g];
    assign dif.cfg_word = s.cfg[g];
    assign dec_err[g] = dif.cfg_err;
    assign dec_notch[g] = dif.notch;
    assign dec_fmt[g] = dif.fmt;
    assign dec_type[g] = dif.type_code;
    assign dec_class[g] = dif.iclass;
  end

  // A finished update with an illegal code is a configuration error event
  assign ev = s.upd & dec_err; // see R3
  assign wr_fire = s.aw_full && s.w_full && !s.bvalid;
  assign ien_we = wr_fire && (s.aw_addr == AICD_OFS_IEN);
  assign iclr_we = wr_fire && (s.aw_addr == AICD_OFS_ICLR);

  aicd_irq #(
    .N(NCH)
  ) u_irq (
    .clk(clk),
    .rstn(rstn),
    .ev(ev),
    .clr_we(iclr_we),
    .en_we(ien_we),
    .wdata(s.w_data[NCH-1:0]),
    .status(mod_cond),
    .enable(irq_en),
    .irq(irq)
  );

  always_comb begin
    logic [CHW-1:0] ch;
    logic [CHW-1:0] rch;
    logic [31:0] rd;
    ch = chan_of(s.aw_addr);
    rch = chan_of(s_axi_araddr);
    rd = 32'h00000000;
    next_s = s;
    next_s.upd = '0;
    // Address and data are taken independently and held until the write
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = addr_ok(s.aw_addr) ? AICD_RESP_OKAY : AICD_RESP_SLVERR;
      if (is_chan(s.aw_addr)) begin
        if (s.aw_addr[3:0] == AICD_OFS_FILT) begin
          next_s.filt[ch] = merge(s.filt[ch], s.w_data, s.w_strb); // see R1
          next_s.upd[ch] = 1'b1;
        end else if (s.aw_addr[3:0] == AICD_OFS_INCFG) begin
          // Bits outside the format and type fields are forced to zero
          next_s.cfg[ch] = merge(s.cfg[ch], s.w_data, s.w_strb) & AICD_INCFG_MASK; // see R7
          next_s.upd[ch] = 1'b1;
        end
      end
    end
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
    // Read data is captured in the cycle the address is taken
    if (is_chan(s_axi_araddr)) begin
      if (s_axi_araddr[3:0] == AICD_OFS_FILT) begin
        rd = s.filt[rch];
      end else if (s_axi_araddr[3:0] == AICD_OFS_INCFG) begin
        rd = s.cfg[rch];
      end else begin
        rd[AICD_ST_FILT_LSB +: 4] = s.ap_notch[rch];
        rd[AICD_ST_FMT_LSB +: 3] = s.ap_fmt[rch];
        rd[AICD_ST_TYPE_LSB +: 6] = s.ap_type[rch];
        rd[AICD_ST_CLASS_LSB +: 3] = s.ap_class[rch];
        rd[AICD_ST_ERR_BIT] = s.ch_err[rch];
      end
    end else if (s_axi_araddr == AICD_OFS_COND) begin
      rd[NCH-1:0] = mod_cond;
    end else if (s_axi_araddr == AICD_OFS_IEN) begin
      rd[NCH-1:0] = irq_en;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd;
      next_s.rresp = addr_ok(s_axi_araddr) ? AICD_RESP_OKAY : AICD_RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
    // A legal update is applied; an illegal one keeps the last good setting
    for (int c = 0; c < NCH; c++) begin
      next_s.ch_err[c] = dec_err[c];
      if (s.upd[c] && !dec_err[c]) begin
        next_s.ap_notch[c] = dec_notch[c]; // see R2
        next_s.ap_fmt[c] = dec_fmt[c]; // see R4, R5
        next_s.ap_type[c] = dec_type[c]; // see R8, R10, R11, R12
        next_s.ap_class[c] = dec_class[c]; // see R9
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      for (int c = 0; c < NCH; c++) begin
        s.filt[c] <= AICD_FILT_RST;
        s.cfg[c] <= AICD_INCFG_RST;
      end
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = !s.aw_full && !s.bvalid;
  assign s_axi_wready = !s.w_full && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign ch_notch = s.ap_notch;
  assign ch_format = s.ap_fmt;
  assign ch_type = s.ap_type;
  assign ch_class = s.ap_class;
  assign ch_cfg_err = s.ch_err;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence filt_write0;
    wr_fire && (s.aw_addr == 8'h00);
  endsequence
  sequence upd_pulse0;
    s.upd[0] ##1 !s.upd[0];
  endsequence

  chk_write_update: assert property (filt_write0 |=> upd_pulse0) // see R1
    else $error("filter write did not pulse update once");
  chk_filt_apply: assert property (s.upd[0] && !dec_err[0] |=> ch_notch[3:0] == $past(s.filt[0][3:0])) // see R1
    else $error("legal filter code not applied");
  chk_notch_legal: assert property (ch_notch[3:0] <= 4'h5) // see R2
    else $error("applied notch code out of range");
  chk_filt_spare: assert property (s.upd[0] && (s.filt[0][3:0] > 4'h5) |=> mod_cond[0] && $stable(ch_notch[3:0])) // see R3
    else $error("spare filter code not flagged");
  chk_fmt_apply: assert property (s.upd[0] && !dec_err[0] |=> ch_format[2:0] == $past(s.cfg[0][10:8])) // see R4
    else $error("format not taken from bits 10..8");
  chk_fmt_spare: assert property (s.upd[0] && (s.cfg[0][10:8] > 3'h4) |=> mod_cond[0] && $stable(ch_format[2:0])) // see R6
    else $error("spare format code not flagged");
  chk_unused_zero: assert property (s.cfg[0][31:11] == 21'h000000 && s.cfg[0][7:6] == 2'b00) // see R7
    else $error("unused configuration bits not zero");
  chk_type_class: assert property (ch_class[2:0] == aicd_type_class(ch_type[5:0]) && ch_type[5:0] <= 6'h20) // see R8, R9
    else $error("applied type and class disagree");
  chk_type_tc: assert property (s.upd[0] && !dec_err[0] && (s.cfg[0][5:0] == 6'h10) |=> ch_class[2:0] == 3'b011) // see R10
    else $error("code 16 not a thermocouple");
  chk_type_rtd: assert property (s.upd[0] && !dec_err[0] && (s.cfg[0][5:0] == 6'h1C) |=> ch_class[2:0] == 3'b100) // see R11
    else $error("code 28 not a resistance thermometer");
  chk_type_res: assert property (s.upd[0] && !dec_err[0] && (s.cfg[0][5:0] == 6'h20) |=> ch_class[2:0] == 3'b101) // see R12
    else $error("code 32 not a plain resistance");
  chk_type_spare: assert property (s.upd[0] && (s.cfg[0][5:0] > 6'h20) |=> mod_cond[0] ##1 ch_cfg_err[0]) // see R13
    else $error("spare type code not flagged");
endmodule : aicd_top

// file: sim/aicd_host_model.sv
// Host controller model that writes and reads the decoder registers over AXI4-Lite
`timescale 1ns/100ps
module aicd_host_model (
  // Clock
  input wire logic clk,
  // Write address and data
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  // Write response
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // Read
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Raised when the slave never answered
  output logic hung
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, hung} = '0;
    awaddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    araddr = 8'h00;
  end

  // Address and data are offered together and each is released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    n = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    while (!(ta && tw) && n < 50) begin
      @(posedge clk);
      n++;
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk);
      n++;
    end while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) hung = 1'b1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!arready && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) hung = 1'b1;
  endtask : rd
endmodule : aicd_host_model

// file: sim/aicd_top_tb_top.sv
// Self-checking bench of the analog input configuration decoder
`timescale 1ns/100ps
module aicd_top_tb_top;
  import aicd_pkg::*;
  typedef struct packed {logic [31:0] f; logic [31:0] c; logic e;} aicd_row_t;
  logic clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, cerr, cond;
  logic [1:0] bresp, rresp;
  logic [15:0] notch;
  logic [11:0] fmt, cls;
  logic [23:0] typ;
  int failures, checks_done, ch;
  aicd_row_t rows [17];
  logic [3:0] gn [4];
  logic [2:0] gf [4];
  logic [5:0] gt [4];

  aicd_top #(.NCH(4)) i_dut (.clk(clk), .rstn(rstn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .ch_notch(notch), .ch_format(fmt), .ch_type(typ), .ch_class(cls), .ch_cfg_err(cerr),
    .mod_cond(cond), .irq(irq));

  aicd_host_model h (.clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .hung());

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    h.wr(a, d, r);
    if (h.hung) begin
      failures++;
      report_and_stop();
    end
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    h.rd(a, d, r);
    if (h.hung) begin
      failures++;
      report_and_stop();
    end
    chk("rdata", d, exp);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask : rdc

  // Sensor class expected for a type and range code
  function automatic logic [2:0] cls_of(input logic [5:0] t);
    if (t > 6'h20) return 3'h7;
    if (t >= 6'h1D) return 3'h5;
    if (t >= 6'h11) return 3'h4;
    if (t >= 6'h08) return 3'h3;
    if (t >= 6'h06) return 3'h2;
    if (t == 6'h03 || t == 6'h05) return 3'h1;
    return 3'h0;
  endfunction : cls_of

  task automatic chk_chan(input int c, input logic e);
    repeat (3) @(posedge clk);
    chk("notch", {28'h0, notch[c*4+:4]}, {28'h0, gn[c]});
    chk("format", {29'h0, fmt[c*3+:3]}, {29'h0, gf[c]});
    chk("type", {26'h0, typ[c*6+:6]}, {26'h0, gt[c]});
    chk("class", {29'h0, cls[c*3+:3]}, {29'h0, cls_of(gt[c])});
    chk("cfg err", {31'h0, cerr[c]}, {31'h0, e});
    rdc(8'(c * 16 + 8), {e, 4'h0, cls_of(gt[c]), 2'h0, gt[c], 5'h0, gf[c], 4'h0, gn[c]}, 2'h0);
  endtask : chk_chan

  initial begin
    rstn = 1'b0;
    failures = 0;
    checks_done = 0;
    for (int i = 0; i < 4; i++) begin
      gn[i] = 4'h0;
      gf[i] = 3'h0;
      gt[i] = 6'h00;
    end
    rows = '{'{32'h0, 32'h11C, 1'b0}, '{32'h1, 32'h103, 1'b0}, '{32'h2, 32'h206, 1'b0},
      '{32'h3, 32'h308, 1'b0}, '{32'h4, 32'h410, 1'b0}, '{32'h5, 32'h011, 1'b0},
      '{32'h0, 32'h11C, 1'b0}, '{32'h1, 32'h21D, 1'b0}, '{32'h2, 32'h320, 1'b0},
      '{32'h6, 32'h001, 1'b1}, '{32'hF, 32'h002, 1'b1}, '{32'h10, 32'h003, 1'b1},
      '{32'h0, 32'h521, 1'b1}, '{32'h1, 32'h700, 1'b1}, '{32'h2, 32'h021, 1'b1},
      '{32'h3, 32'h03F, 1'b1}, '{32'h3, 32'h80000407, 1'b0}};
    repeat (5) @(posedge clk);
    chk("reset outputs", 32'({notch, cerr, cond, irq}), 32'h0);
    rstn <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      ch = i % 4;
      wr(8'(ch * 16), rows[i].f, 2'h0);
      // A legal filter word is applied at once against the still legal stored config
      if (rows[i].f[31:4] == 28'h0 && rows[i].f[3:0] <= AICD_FILT_MAX) gn[ch] = rows[i].f[3:0];
      wr(8'(ch * 16 + 4), rows[i].c, 2'h0);
      if (!rows[i].e) begin
        gn[ch] = rows[i].f[3:0];
        gf[ch] = rows[i].c[10:8];
        gt[ch] = rows[i].c[5:0];
      end
      chk_chan(ch, rows[i].e);
      rdc(8'(ch * 16 + 4), rows[i].c & 32'h0000073F, 2'h0);
      chk("cond", {31'h0, cond[ch]}, {31'h0, rows[i].e});
      if (rows[i].e) begin
        wr(8'(ch * 16), 32'h0, 2'h0);
        wr(8'(ch * 16 + 4), 32'h0, 2'h0);
        wr(8'h48, 32'(1 << ch), 2'h0);
        gn[ch] = 4'h0;
        gf[ch] = 3'h0;
        gt[ch] = 6'h00;
        chk_chan(ch, 1'b0);
        chk("cond clear", {28'h0, cond}, 32'h0);
      end
    end
    // Masked event leaves the interrupt low until the enable is set
    wr(8'h30, 32'h9, 2'h0);
    repeat (3) @(posedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdc(8'h40, 32'h8, 2'h0);
    wr(8'h44, 32'hF, 2'h0);
    rdc(8'h44, 32'hF, 2'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h30, 32'h0, 2'h0);
    wr(8'h48, 32'h8, 2'h0);
    rdc(8'h48, 32'h0, 2'h0);
    repeat (3) @(posedge clk);
    chk("irq off", {31'h0, irq}, 32'h0);
    // Unmapped and misaligned places answer with an error and no data
    rdc(8'h4C, 32'h0, 2'h2);
    rdc(8'h02, 32'h0, 2'h2);
    wr(8'h50, 32'hFFFFFFFF, 2'h2);
    report_and_stop();
  end
endmodule : aicd_top_tb_top
